// ---- bench/ssp_host.sv ----
// Host serial master model for the sensor serial port.
// Assumes clk_sys at 100 MHz; serial bit time is 8 cycles (80 ns).
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
   input wire logic clk_sys,
   output logic sclk,
   output logic sel_n,
   output logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe_n
);
   logic last_ff = 1'b0;
   logic line;
   // Released line shows the inverse of its last level
   assign line = miso_oe_n ? ~last_ff : miso_o;
   always @(posedge clk_sys) begin
      if (!miso_oe_n) last_ff <= miso_o;
   end
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_clk
   // n bits: 8 instruction bits, then argument bits captured MSB first
   task automatic xfer(input logic [7:0] cmd, input int n, output logic [31:0] rx, output logic ran);
      rx = 32'h00000000;
      ran = 1'b0;
      @(posedge clk_sys);
      sel_n <= 1'b0;
      wait_clk(8);
      for (int i = 0; i < n; i++) begin
         mosi <= (i < 8) ? cmd[7 - i] : 1'b0;
         wait_clk(4);
         if (i >= 8) rx = {rx[30:0], line};
         ran = ran | !miso_oe_n;
         sclk <= 1'b1;
         wait_clk(4);
         sclk <= 1'b0;
      end
      wait_clk(8);
      sel_n <= 1'b1;
      wait_clk(8);
   endtask : xfer
endmodule : ssp_host
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the sensor serial slave port.
// Assumes ssp_host drives the serial pins; samples pushed by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic enable = 1'b1;
   logic calib_reload_reset_n = 1'b1;
   logic smp_valid = 1'b0;
   logic smp_st_ok = 1'b1;
   logic [23:0] smp_acc = 24'h000000;
   logic [13:0] smp_temp = 14'h0000;
   logic sclk, sel_n, mosi, miso_o, miso_oe_n, sample_ready_pulse;
   logic selftest_ok, calib_reload, smp_ready, ran;
   logic [31:0] rx;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int pulses = 0;
   int p0;
   always #5 clk_sys = ~clk_sys;
   ssp_host host (.clk_sys(clk_sys), .sclk(sclk), .sel_n(sel_n), .mosi(mosi),
      .miso_o(miso_o), .miso_oe_n(miso_oe_n));
   ssp_slave #(.FIFO_DEPTH(16)) dut (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
      .sel_n(sel_n), .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
      .sample_ready_pulse(sample_ready_pulse), .selftest_ok(selftest_ok),
      .enable(enable), .calib_reload_reset_n(calib_reload_reset_n),
      .calib_reload(calib_reload), .smp_valid(smp_valid), .smp_ready(smp_ready),
      .smp_acc(smp_acc), .smp_temp(smp_temp), .smp_st_ok(smp_st_ok));
   task automatic end_of_test();
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (sample_ready_pulse === 1'b1) pulses <= pulses + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic push(input logic [23:0] a, input logic [13:0] t, input logic s);
      p0 = pulses;
      @(posedge clk_sys);
      smp_acc <= a;
      smp_temp <= t;
      smp_st_ok <= s;
      smp_valid <= 1'b1;
      @(posedge clk_sys);
      smp_valid <= 1'b0;
      repeat (10) @(posedge clk_sys);
      #1 chk(pulses - p0, 1);
   endtask : push
   task automatic t_reset();
      #1 chk({miso_oe_n, selftest_ok, calib_reload, smp_ready}, 4'hD);
   endtask : t_reset
   task automatic t_acc();
      push(24'h95303F, 14'h1F40, 1'b1);
      chk(selftest_ok, 1);
      host.xfer(ssp_pkg::CMD_READ_ACC, 40, rx, ran);
      chk(rx, {24'h95303F, 8'h03});
      host.xfer(ssp_pkg::CMD_READ_ACC, 40, rx, ran);
      chk(rx, {24'h95303F, 8'h01});
      chk(miso_oe_n, 1);
      host.xfer(8'hA5, 40, rx, ran);
      chk(rx, 32'h00000000);
      chk(ran, 1);
   endtask : t_acc
   task automatic t_fail_temp();
      push(24'h6ACFC0, 14'h0123, 1'b0);
      chk(selftest_ok, 0);
      host.xfer(ssp_pkg::CMD_READ_ACC, 40, rx, ran);
      chk(rx, {24'h6ACFC0, 8'h02});
      host.xfer(8'h54, 4, rx, ran);
      host.xfer(ssp_pkg::CMD_READ_TEMP, 24, rx, ran);
      chk(rx, {16'h0000, 14'h0123, 2'b00});
   endtask : t_fail_temp
   task automatic t_reload();
      @(posedge clk_sys);
      calib_reload_reset_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 chk({calib_reload, selftest_ok}, 2'h3);
      @(posedge clk_sys);
      calib_reload_reset_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 chk(calib_reload, 0);
   endtask : t_reload
   task automatic t_fill();
      @(posedge clk_sys);
      enable <= 1'b0;
      host.xfer(ssp_pkg::CMD_READ_ACC, 40, rx, ran);
      chk(ran, 0);
      p0 = pulses;
      smp_valid <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         smp_acc <= 24'(i);
         @(posedge clk_sys);
      end
      smp_valid <= 1'b0;
      #1 chk(smp_ready, 0);
      @(posedge clk_sys);
      enable <= 1'b1;
      repeat (200) @(posedge clk_sys);
      #1 chk(pulses - p0, 16);
      chk(smp_ready, 1);
   endtask : t_fill
   initial begin
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_acc();
      t_fail_temp();
      t_reload();
      t_fill();
      end_of_test();
   end
endmodule : tb
`default_nettype wire

// ---- src/ssp_fifo.sv ----
// Sample FIFO between the sensor core and the serial port.
// Assumes both sides on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
   parameter int unsigned WIDTH = 39,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } ssp_fifo_state_t;
   ssp_fifo_state_t st_ff;
   ssp_fifo_state_t nxt_st;
   logic push;
   logic pop;

   always_comb begin
      push = in_valid && (st_ff.cnt != (AW+1)'(DEPTH));
      pop = out_ready && (st_ff.cnt != '0);
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr] = in_data;
         nxt_st.wr = st_ff.wr + 1'b1;
      end
      if (pop) begin
         nxt_st.rd = st_ff.rd + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign in_ready = st_ff.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_ff.cnt != '0;
   assign out_data = st_ff.mem[st_ff.rd];
endmodule : ssp_fifo
`default_nettype wire

// ---- src/ssp_pkg.sv ----
// Package for the sensor serial slave port: frame layout, commands, timing.
// Assumes a 100 MHz system clock; serial pins arrive asynchronously.
package ssp_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned SPI_MAX_KHZ = 8000;
   localparam int unsigned SPI_TYP_KHZ = 200;
   localparam logic [7:0] CMD_READ_ACC = 8'h50;
   localparam logic [7:0] CMD_READ_TEMP = 8'h54;
   localparam int unsigned ACC_ARG_BYTES = 4;
   localparam int unsigned TEMP_ARG_BYTES = 2;
   localparam int unsigned ACC_W = 24;
   localparam int unsigned TEMP_W = 14;
   localparam int unsigned FRAME_W = 32;
   localparam int unsigned FRAME_RDY_POS = 1;
   localparam int unsigned FRAME_ST_POS = 0;
   localparam int unsigned ACC_LSB_POS = 8;
   localparam int unsigned TEMP_LSB_POS = 2;
   localparam logic [31:0] FRAME_RST = 32'h00000000;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [5:0] BITCNT_RST = 6'h00;

   typedef enum logic [1:0] {
      SSP_IDLE = 2'b00,
      SSP_CMD = 2'b01,
      SSP_ARG = 2'b10
   } ssp_state_t;

   // One sample from the sensor core
   typedef struct packed {
      logic [23:0] acc;
      logic [13:0] temp;
      logic st_ok;
   } ssp_sample_t;

   // Synchronised serial pins
   typedef struct packed {
      logic sclk;
      logic sel_n;
      logic mosi;
   } ssp_pins_t;
endpackage : ssp_pkg

// ---- src/ssp_slave.sv ----
// Serial slave port and status pins of a single-axis accelerometer.
// Assumes the host drives sclk, sel_n and mosi asynchronously; sclk is
// oversampled by clk_sys (at most 8 MHz against 100 MHz).
`timescale 1ns/1ps
`default_nettype none
module ssp_slave #(
   parameter int unsigned FIFO_DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   output logic miso_o,
   output logic miso_oe_n,
   output logic sample_ready_pulse,
   output logic selftest_ok,
   input wire logic enable,
   input wire logic calib_reload_reset_n,
   output logic calib_reload,
   input wire logic smp_valid,
   output logic smp_ready,
   input wire logic [23:0] smp_acc,
   input wire logic [13:0] smp_temp,
   input wire logic smp_st_ok
);
   typedef struct packed {
      ssp_pkg::ssp_pins_t s1;
      ssp_pkg::ssp_pins_t s2;
      logic sclk_d;
      logic en1;
      logic en2;
      logic rl1;
      logic rl2;
      ssp_pkg::ssp_state_t fsm;
      logic [5:0] bitcnt;
      logic [7:0] cmd;
      logic [31:0] shreg;
      ssp_pkg::ssp_sample_t cur;
      logic rdy;
      logic miso;
      logic oe_n;
      logic pulse;
      logic st;
      logic reload;
   } ssp_slave_state_t;

   ssp_slave_state_t st_ff;
   ssp_slave_state_t nxt_st;
   ssp_pkg::ssp_sample_t fifo_in;
   ssp_pkg::ssp_sample_t fifo_out;
   logic fifo_valid;
   logic fifo_take;
   logic rise;
   logic fall;
   logic [7:0] cmd_full;

   assign fifo_in = '{acc: smp_acc, temp: smp_temp, st_ok: smp_st_ok};

   ssp_fifo #(
      .WIDTH($bits(ssp_pkg::ssp_sample_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(smp_valid),
      .in_ready(smp_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(fifo_take),
      .out_data(fifo_out)
   );

   // Edges of the oversampled serial clock, mode 0 only
   assign rise = st_ff.s2.sclk && !st_ff.sclk_d;
   assign fall = !st_ff.s2.sclk && st_ff.sclk_d;
   assign cmd_full = {st_ff.cmd[6:0], st_ff.s2.mosi};
   // New sample taken only outside a frame so the shift data stays stable
   // At most one take every second cycle, so back-to-back samples give separate pulses
   assign fifo_take = fifo_valid && st_ff.en2 && (st_ff.fsm == ssp_pkg::SSP_IDLE) && !st_ff.pulse;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = '{sclk: sclk, sel_n: sel_n, mosi: mosi};
      nxt_st.s2 = st_ff.s1;
      nxt_st.sclk_d = st_ff.s2.sclk;
      nxt_st.en1 = enable;
      nxt_st.en2 = st_ff.en1;
      nxt_st.rl1 = calib_reload_reset_n;
      nxt_st.rl2 = st_ff.rl1;
      nxt_st.reload = !st_ff.rl2;
      nxt_st.pulse = 1'b0;
      if (fifo_take) begin
         nxt_st.cur = fifo_out;
         nxt_st.rdy = 1'b1;
         nxt_st.st = fifo_out.st_ok;
         nxt_st.pulse = 1'b1;
      end
      if (!st_ff.rl2) begin
         nxt_st.st = 1'b1;
      end
      case (st_ff.fsm)
         ssp_pkg::SSP_IDLE: begin
            nxt_st.oe_n = 1'b1;
            if (!st_ff.s2.sel_n && st_ff.en2) begin
               nxt_st.fsm = ssp_pkg::SSP_CMD;
               nxt_st.bitcnt = ssp_pkg::BITCNT_RST;
               nxt_st.cmd = ssp_pkg::CMD_RST;
               nxt_st.oe_n = 1'b0;
               nxt_st.miso = 1'b0;
            end
         end
         ssp_pkg::SSP_CMD: begin
            if (rise) begin
               nxt_st.cmd = cmd_full;
               nxt_st.bitcnt = st_ff.bitcnt + 6'h01;
               if (st_ff.bitcnt == 6'h07) begin
                  nxt_st.fsm = ssp_pkg::SSP_ARG;
                  nxt_st.bitcnt = ssp_pkg::BITCNT_RST;
                  if (cmd_full == ssp_pkg::CMD_READ_ACC) begin
                     nxt_st.shreg = {st_ff.cur.acc, 6'h00, st_ff.rdy, st_ff.st};
                     nxt_st.rdy = fifo_take;
                  end else if (cmd_full == ssp_pkg::CMD_READ_TEMP) begin
                     nxt_st.shreg = {st_ff.cur.temp, 2'h0, 16'h0000};
                  end else begin
                     nxt_st.shreg = ssp_pkg::FRAME_RST;
                  end
               end
            end
         end
         ssp_pkg::SSP_ARG: begin
            if (fall) begin
               nxt_st.miso = st_ff.shreg[ssp_pkg::FRAME_W-1];
               nxt_st.shreg = {st_ff.shreg[ssp_pkg::FRAME_W-2:0], 1'b0};
            end
         end
         default: begin
            nxt_st.fsm = ssp_pkg::SSP_IDLE;
         end
      endcase
      if (st_ff.s2.sel_n || !st_ff.en2) begin
         nxt_st.fsm = ssp_pkg::SSP_IDLE;
         nxt_st.oe_n = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_ff <= '0;
         st_ff.s1.sel_n <= 1'b1;
         st_ff.s2.sel_n <= 1'b1;
         st_ff.oe_n <= 1'b1;
         st_ff.st <= 1'b1;
         st_ff.rl1 <= 1'b1;
         st_ff.rl2 <= 1'b1;
         st_ff.fsm <= ssp_pkg::SSP_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign miso_o = st_ff.miso;
   assign miso_oe_n = st_ff.oe_n;
   assign sample_ready_pulse = st_ff.pulse;
   assign selftest_ok = st_ff.st;
   assign calib_reload = st_ff.reload;

   chk_release_when_idle: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(st_ff.s2.sel_n) |=> miso_oe_n)
      else $error("miso driven after deselect");
   chk_pulse_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
      sample_ready_pulse |=> !sample_ready_pulse)
      else $error("ready pulse longer than one cycle");
   chk_pulse_sets_flag: assert property (@(posedge clk_sys) disable iff (srst)
      sample_ready_pulse |-> st_ff.rdy)
      else $error("ready flag not set with pulse");
   chk_reload_follows_pin: assert property (@(posedge clk_sys) disable iff (srst)
      !calib_reload_reset_n [*3] |=> calib_reload)
      else $error("reload not raised");
   chk_selftest_mirror: assert property (@(posedge clk_sys) disable iff (srst)
      (fifo_take && st_ff.rl2) |=> (selftest_ok == $past(fifo_out.st_ok)))
      else $error("self-test bit not refreshed");
   chk_miso_change_fall: assert property (@(posedge clk_sys) disable iff (srst)
      ($changed(miso_o) && !miso_oe_n && $past(!miso_oe_n)) |-> $past(fall))
      else $error("miso changed off a falling edge");
   chk_cmd_then_arg: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.fsm == ssp_pkg::SSP_ARG) |-> $past(st_ff.fsm == ssp_pkg::SSP_CMD || st_ff.fsm == ssp_pkg::SSP_ARG))
      else $error("argument phase without instruction");
   chk_deselect_ends: assert property (@(posedge clk_sys) disable iff (srst)
      st_ff.s2.sel_n |=> (st_ff.fsm == ssp_pkg::SSP_IDLE))
      else $error("frame survives deselect");

   // Flag clearing, disable, reload and frame start
   chk_read_clears_flag: assert property (@(posedge clk_sys) disable iff (srst)
      (st_ff.fsm == ssp_pkg::SSP_CMD && rise && st_ff.bitcnt == 6'h07 && cmd_full == ssp_pkg::CMD_READ_ACC)
      |=> !st_ff.rdy)
      else $error("ready flag kept after read");
   chk_disable_idles: assert property (@(posedge clk_sys) disable iff (srst)
      !st_ff.en2 |=> (st_ff.fsm == ssp_pkg::SSP_IDLE && miso_oe_n))
      else $error("port active while disabled");
   chk_reload_forces_ok: assert property (@(posedge clk_sys) disable iff (srst)
      !st_ff.rl2 |=> selftest_ok)
      else $error("self-test low during reload");
   chk_frame_starts_driven: assert property (@(posedge clk_sys) disable iff (srst)
      (!st_ff.s2.sel_n && st_ff.en2 && st_ff.fsm == ssp_pkg::SSP_IDLE) |=> !miso_oe_n)
      else $error("output not driven at frame start");
endmodule : ssp_slave
`default_nettype wire
